// file: verilog/rmocr_regs.sv
/*
 * Mode register slice of a two-channel DRAM die: bank and segment
 * refresh masks, strobe oscillator count readback, upper-byte read
 * calibration invert. Assumes the command decoder hands over mode
 * register writes, reads, oscillator commands and refresh requests as
 * one-cycle strobes on SYS_CLK.
 */
// What this block does
// R1: a bank whose mask bit is one is not refreshed.
// R2: each channel holds its own bank refresh mask.
// R3: segment mask bit n covers rows whose top three row bits equal n.
// R4: each channel holds its own segment refresh mask.
// R5: the low count register reads the low byte of the oscillator count.
// R6: the high count register reads the high byte of the oscillator count.
// R7: the controller reads both count bytes and joins them itself.
// R8: a start oscillator command clears both count bytes.
// R9: the controller may use the count to retune strobe phase.
// R10: the write-only invert register picks inverted upper data lines.
// R11: invert bits 0-3 drive lines 8-11 and bits 4-7 drive lines 12-15.
// R12: during calibration the upper mask/inversion pin carries the true pattern.
// R13: no bus inversion is applied to calibration output.
// R14: a segment mask bit of one skips refresh, zero keeps it unless the bank mask bit is one.
`timescale 1ns/1ps
module rmocr_regs
   import rmocr_pkg::*;
(
   // clock, reset, enable
   input  wire logic              SYS_CLK,
   input  wire logic              RST_N,
   input  wire logic              CE,
   // mode register write
   input  wire logic              MRW_VALID,
   input  wire logic [CH_W-1:0]   MRW_CH,
   input  wire logic [MA_W-1:0]   MRW_MA,
   input  wire logic [OP_W-1:0]   MRW_OP,
   // mode register read
   input  wire logic              MRR_VALID,
   input  wire logic [CH_W-1:0]   MRR_CH,
   input  wire logic [MA_W-1:0]   MRR_MA,
   output logic                   RD_VALID,
   output logic      [OP_W-1:0]   RD_DATA,
   // oscillator commands, one bit per channel
   input  wire logic [NUM_CH-1:0] OSC_START,
   input  wire logic [NUM_CH-1:0] OSC_STOP,
   input  wire logic [NUM_CH-1:0] OSC_TICK,
   output logic      [NUM_CH-1:0] OSC_RUNNING,
   // refresh request
   input  wire logic              REF_VALID,
   input  wire logic [CH_W-1:0]   REF_CH,
   input  wire logic [BANK_W-1:0] REF_BANK,
   input  wire logic [ROW_W-1:0]  REF_ROW,
   input  wire logic              DENSITY_4G,
   output logic                   REF_DONE,
   output logic                   REF_SKIPPED,
   // upper byte read data path
   input  wire logic              CAL_ACTIVE,
   input  wire logic [CH_W-1:0]   CAL_CH,
   input  wire logic              CAL_BIT,
   input  wire logic              DBI_EN,
   input  wire logic              RD_STROBE,
   input  wire logic [OP_W-1:0]   RD_UPPER_IN,
   output logic      [OP_W-1:0]   DQ_UPPER_OUT,
   output logic                   DMI_UPPER_OUT
);

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_meta_ff;
   logic rst_n;

   // assert at once, release two edges later
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_meta_ff <= 1'b0;
         rst_n       <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_n       <= rst_meta_ff;
      end
   end

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!rst_n);

   // ****************************************************************
   // per-channel registers
   // ****************************************************************
   logic [OP_W-1:0]  bank_mask_ff [NUM_CH];
   logic [OP_W-1:0]  seg_mask_ff  [NUM_CH];
   logic [OP_W-1:0]  inv_mask_ff  [NUM_CH];
   logic [CNT_W-1:0] osc_cnt      [NUM_CH];

   wire logic mrw_take = CE && MRW_VALID;
   wire logic mrr_take = CE && MRR_VALID;
   wire logic ref_take = CE && REF_VALID;
   wire logic cal_take = CE && RD_STROBE && CAL_ACTIVE;

   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_ch
      wire logic wr_ch = mrw_take && (MRW_CH == CH_W'(c));

      // separate copies per channel so both may differ
      always_ff @(posedge SYS_CLK or negedge rst_n)
      begin
         if (!rst_n)
         begin
            bank_mask_ff[c] <= MASK_RST;
            seg_mask_ff[c]  <= MASK_RST;
            inv_mask_ff[c]  <= INV_RST;
         end
         else if (CE)
         begin
            if (wr_ch && MRW_MA == MA_BANK_MASK)
               bank_mask_ff[c] <= MRW_OP; // R2
            if (wr_ch && MRW_MA == MA_SEG_MASK)
               seg_mask_ff[c]  <= MRW_OP; // R4
            if (wr_ch && MRW_MA == MA_UPPER_INV)
               inv_mask_ff[c]  <= MRW_OP; // R10
         end
      end

      rmocr_osc_counter u_osc (
         .clk     (SYS_CLK),
         .rst_n   (rst_n),
         .ce      (CE),
         .start   (OSC_START[c]),
         .stop    (OSC_STOP[c]),
         .tick    (OSC_TICK[c]),
         .count   (osc_cnt[c]),
         .running (OSC_RUNNING[c])
      );
   end

   // ****************************************************************
   // mode register read
   // ****************************************************************
   // write-only and unmapped addresses answer zero
   wire logic [CNT_W-1:0] rd_cnt  = osc_cnt[MRR_CH];
   wire logic [OP_W-1:0]  rd_low  = rd_cnt[OSC_LOW_LSB +: OP_W];  // R5
   wire logic [OP_W-1:0]  rd_high = rd_cnt[OSC_HIGH_LSB +: OP_W]; // R6
   wire logic [OP_W-1:0]  nxt_rd_data =
      (MRR_MA == MA_OSC_LOW)  ? rd_low  :
      (MRR_MA == MA_OSC_HIGH) ? rd_high : RD_ZERO;

   logic            rd_valid_ff;
   logic [OP_W-1:0] rd_data_ff;

   // answer one edge after the read is taken
   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_valid_ff <= 1'b0;
         rd_data_ff  <= RD_ZERO;
      end
      else if (CE)
      begin
         rd_valid_ff <= mrr_take;
         if (mrr_take)
            rd_data_ff <= nxt_rd_data;
      end
   end

   assign RD_VALID = rd_valid_ff;
   assign RD_DATA  = rd_data_ff;

   // ****************************************************************
   // refresh masking
   // ****************************************************************
   // the segment field moves up one row bit on the larger die
   wire logic [SEG_W-1:0] seg_idx = DENSITY_4G ?
      REF_ROW[SEG_LSB_4G +: SEG_W] : REF_ROW[SEG_LSB_2G +: SEG_W]; // R3
   wire logic bank_hit = bank_mask_ff[REF_CH][REF_BANK]; // R1
   wire logic seg_hit  = seg_mask_ff[REF_CH][seg_idx];   // R14
   wire logic suppress = bank_hit || seg_hit;

   logic ref_done_ff;
   logic ref_skip_ff;

   // exactly one of done or skipped answers each request
   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_done_ff <= 1'b0;
         ref_skip_ff <= 1'b0;
      end
      else if (CE)
      begin
         ref_done_ff <= ref_take && !suppress;
         ref_skip_ff <= ref_take && suppress; // R1
      end
   end

   assign REF_DONE    = ref_done_ff;
   assign REF_SKIPPED = ref_skip_ff;

   // ****************************************************************
   // upper byte read path
   // ****************************************************************
   logic [ONES_W-1:0] ones;

   // count ones to decide normal-read bus inversion
   always_comb
   begin
      ones = '0;
      for (int i = 0; i < OP_W; i++)
         ones = ones + ONES_W'(RD_UPPER_IN[i]);
   end

   wire logic            dbi_flip = DBI_EN && (ones > DBI_LIMIT);
   wire logic [OP_W-1:0] cal_inv  = inv_mask_ff[CAL_CH];
   // bit k of the mask drives line 8+k; the pin between them is untouched
   wire logic [OP_W-1:0] cal_dq   = {OP_W{CAL_BIT}} ^ cal_inv; // R11
   wire logic [OP_W-1:0] nrm_dq   = dbi_flip ? ~RD_UPPER_IN : RD_UPPER_IN;
   // calibration ignores the inversion enable entirely
   wire logic [OP_W-1:0] nxt_dq   = CAL_ACTIVE ? cal_dq : nrm_dq;  // R13
   wire logic            nxt_dmi  = CAL_ACTIVE ? CAL_BIT : dbi_flip; // R12

   logic [OP_W-1:0] dq_ff;
   logic            dmi_ff;

   // outputs move only on a read beat, so they hold between beats
   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dq_ff  <= RD_ZERO;
         dmi_ff <= 1'b0;
      end
      else if (CE && RD_STROBE)
      begin
         dq_ff  <= nxt_dq;
         dmi_ff <= nxt_dmi;
      end
   end

   assign DQ_UPPER_OUT  = dq_ff;
   assign DMI_UPPER_OUT = dmi_ff;

   // ****************************************************************
   // checks
   // ****************************************************************
   wire logic [SEG_W-1:0] chk_seg = DENSITY_4G ? REF_ROW[14:12] : REF_ROW[13:11];
   wire logic [OP_W-1:0]  chk_low  = osc_cnt[MRR_CH][7:0];
   wire logic [OP_W-1:0]  chk_high = osc_cnt[MRR_CH][15:8];

   AST_BANK_SKIP: assert property ( // R1
      ref_take && bank_mask_ff[REF_CH][REF_BANK] |=> REF_SKIPPED && !REF_DONE)
      else $error("masked bank was refreshed");

   AST_BANK_PER_CH: assert property ( // R2
      mrw_take && MRW_CH == 1'b0 && MRW_MA == MA_BANK_MASK |=> $stable(bank_mask_ff[1]))
      else $error("bank mask write leaked into other channel");

   AST_SEG_SELECT: assert property ( // R3
      ref_take && seg_mask_ff[REF_CH][chk_seg] |=> REF_SKIPPED)
      else $error("masked segment was refreshed");

   AST_SEG_PER_CH: assert property ( // R4
      mrw_take && MRW_CH == 1'b1 && MRW_MA == MA_SEG_MASK |=> $stable(seg_mask_ff[0]))
      else $error("segment mask write leaked into other channel");

   AST_RD_LOW: assert property ( // R5
      mrr_take && MRR_MA == MA_OSC_LOW |=> RD_VALID && RD_DATA == $past(chk_low))
      else $error("low count byte read wrong");

   AST_RD_HIGH: assert property ( // R6
      mrr_take && MRR_MA == MA_OSC_HIGH |=> RD_VALID && RD_DATA == $past(chk_high))
      else $error("high count byte read wrong");

   AST_START_CLEAR: assert property ( // R8
      CE && OSC_START[0] |=> osc_cnt[0] == CNT_RST)
      else $error("start did not clear count");

   AST_INV_MAP: assert property ( // R11
      cal_take |=> DQ_UPPER_OUT == ({OP_W{$past(CAL_BIT)}} ^ $past(cal_inv)))
      else $error("calibration invert mapping wrong");

   AST_DMI_TRUE: assert property ( // R12
      cal_take |=> DMI_UPPER_OUT == $past(CAL_BIT))
      else $error("mask pin inverted during calibration");

   AST_NO_DBI: assert property ( // R13
      cal_take && DBI_EN && cal_inv == RD_ZERO |=> DQ_UPPER_OUT == {OP_W{$past(CAL_BIT)}})
      else $error("bus inversion applied to calibration");

   AST_SEG_KEEP: assert property ( // R14
      ref_take && !bank_hit && !seg_mask_ff[REF_CH][chk_seg] |=> REF_DONE && !REF_SKIPPED)
      else $error("unmasked row was skipped");

   COV_MRW: cover property (mrw_take && MRW_MA == MA_BANK_MASK);
   COV_SKIP: cover property (ref_take && suppress);
   COV_CAL: cover property (cal_take && DBI_EN);
   COV_RD_HIGH: cover property (mrr_take && MRR_MA == MA_OSC_HIGH);

endmodule // rmocr_regs

// file: include/rmocr_pkg.sv
/*
 * Shared constants for the refresh mask, strobe oscillator count and
 * upper-byte calibration invert register slice of one DRAM die.
 * Assumes a single command clock and a decoded mode register port.
 */
package rmocr_pkg;

   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int NUM_CH = 2;
   localparam int CH_W   = 1;
   localparam int MA_W   = 6;
   localparam int OP_W   = 8;
   localparam int CNT_W  = 16;
   localparam int ROW_W  = 15;
   localparam int BANK_W = 3;
   localparam int SEG_W  = 3;
   localparam int ONES_W = 4;

   // ****************************************************************
   // mode register addresses
   // ****************************************************************
   localparam logic [MA_W-1:0] MA_BANK_MASK = 6'h10;
   localparam logic [MA_W-1:0] MA_SEG_MASK  = 6'h11;
   localparam logic [MA_W-1:0] MA_OSC_LOW   = 6'h12;
   localparam logic [MA_W-1:0] MA_OSC_HIGH  = 6'h13;
   localparam logic [MA_W-1:0] MA_UPPER_INV = 6'h14;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int SEG_LSB_2G   = 11;
   localparam int SEG_LSB_4G   = 12;
   localparam int OSC_LOW_LSB  = 0;
   localparam int OSC_HIGH_LSB = 8;

   localparam logic [OP_W-1:0]   MASK_RST = 8'h00;
   localparam logic [OP_W-1:0]   INV_RST  = 8'h00;
   localparam logic [OP_W-1:0]   RD_ZERO  = 8'h00;
   localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_MAX  = 16'hFFFF;
   localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;
   localparam logic [ONES_W-1:0] DBI_LIMIT = 4'h4;

   // ****************************************************************
   // oscillator counter states
   // ****************************************************************
   typedef enum logic {OSC_IDLE, OSC_RUN} rmocr_osc_state_t;

endpackage

// file: verilog/rmocr_osc_counter.sv
/*
 * Strobe oscillator counter for one channel: a start command clears the
 * count and starts it, ticks add one, stop freezes the result.
 * Assumes start, stop and tick come from logic on the same clock.
 */
`timescale 1ns/1ps
module rmocr_osc_counter
   import rmocr_pkg::*;
(
   // clock, reset, enable
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // control
   input  wire logic             start,
   input  wire logic             stop,
   input  wire logic             tick,
   // result
   output logic      [CNT_W-1:0] count,
   output logic                  running
);

   rmocr_osc_state_t state_ff;
   rmocr_osc_state_t nxt_state;
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;
   wire  logic       inc;

   // a restart while running clears and keeps counting
   always_comb
   begin
      case (state_ff)
         OSC_IDLE: nxt_state = start ? OSC_RUN : OSC_IDLE;
         OSC_RUN:  nxt_state = (stop && !start) ? OSC_IDLE : OSC_RUN;
         default:  nxt_state = OSC_IDLE;
      endcase
   end

   // saturate rather than wrap so a long run never reads as short
   assign inc       = (state_ff == OSC_RUN) && tick && (count_ff != CNT_MAX);
   assign nxt_count = start ? CNT_RST : (inc ? count_ff + CNT_ONE : count_ff); // R8

   // state and count
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= OSC_IDLE;
         count_ff <= CNT_RST;
      end
      else if (ce)
      begin
         state_ff <= nxt_state;
         count_ff <= nxt_count;
      end
   end

   assign count   = count_ff;
   assign running = (state_ff == OSC_RUN);

endmodule // rmocr_osc_counter

// file: dv/rmocr_ctrl_model.sv
/*
 * Memory controller model: issues mode register writes and reads.
 * Assumes it shares SYS_CLK with the register slice and changes
 * its requests at falling edges.
 */
`timescale 1ns/1ps
module rmocr_ctrl_model
   import rmocr_pkg::*;
(
   // clock and read answer
   input  wire logic            clk,
   input  wire logic            rd_valid,
   input  wire logic [OP_W-1:0] rd_data,
   // write request
   output logic                 mrw_valid,
   output logic      [CH_W-1:0] mrw_ch,
   output logic      [MA_W-1:0] mrw_ma,
   output logic      [OP_W-1:0] mrw_op,
   // read request
   output logic                 mrr_valid,
   output logic      [CH_W-1:0] mrr_ch,
   output logic      [MA_W-1:0] mrr_ma
);
   // idle request lines
   initial
   begin
      mrw_valid = 1'b0;
      mrr_valid = 1'b0;
      {mrw_ch, mrw_ma, mrw_op, mrr_ch, mrr_ma} = '0;
   end

   // one byte per write; released address and data lines show the inverse, the channel line keeps its value
   task automatic mrw(input logic [CH_W-1:0] ch, input logic [MA_W-1:0] ma,
                      input logic [OP_W-1:0] op);
      @(negedge clk);
      mrw_valid = 1'b1;
      mrw_ch    = ch;
      mrw_ma    = ma;
      mrw_op    = op;
      @(negedge clk);
      mrw_valid = 1'b0;
      mrw_ma    = ~ma;
      mrw_op    = ~op;
   endtask

   // read with a bounded wait for the answer strobe
   task automatic mode_register_read_cmd(input logic [CH_W-1:0] ch, input logic [MA_W-1:0] ma,
                      output logic [OP_W-1:0] data, output logic ok);
      int n;
      ok   = 1'b0;
      data = 8'h00;
      @(negedge clk);
      mrr_valid = 1'b1;
      mrr_ch    = ch;
      mrr_ma    = ma;
      for (n = 0; n < 2 && !ok; n++)
      begin
         @(negedge clk);
         mrr_valid = 1'b0;
         mrr_ma    = ~ma;
         if (rd_valid === 1'b1)
         begin
            ok   = 1'b1;
            data = rd_data;
         end
      end
   endtask

   // both count bytes are read and joined here, the slice never joins them
   task automatic read_count(input logic [CH_W-1:0] ch, output logic [CNT_W-1:0] cnt,
                             output logic ok);
      logic [OP_W-1:0] hi;
      logic [OP_W-1:0] lo;
      logic            ok_hi;
      mode_register_read_cmd(ch, MA_OSC_HIGH, hi, ok_hi);
      mode_register_read_cmd(ch, MA_OSC_LOW, lo, ok);
      ok  = ok & ok_hi;
      cnt = {hi, lo};
   endtask
endmodule // rmocr_ctrl_model

// file: dv/refresh_mask_osc_count_regs_tb.sv
/*
 * Self-checking bench for the register slice: refresh masks, oscillator
 * count readback and calibration invert. Assumes rmocr_ctrl_model as the
 * controller; all other inputs change at falling edges.
 */
`timescale 1ns/1ps
module refresh_mask_osc_count_regs_tb
   import rmocr_pkg::*;
;
   logic sys_clk, rst_n, ce, rd_valid, ref_valid, density_4g, ref_done, ref_skipped;
   logic mrw_valid, mrr_valid, cal_active, cal_bit, dbi_en, rd_strobe, dmi_upper_out;
   logic [CH_W-1:0] mrw_ch, mrr_ch, ref_ch, cal_ch;
   logic [MA_W-1:0] mrw_ma, mrr_ma;
   logic [OP_W-1:0] mrw_op, rd_data, rd_upper_in, dq_upper_out;
   logic [NUM_CH-1:0] osc_start, osc_stop, osc_tick, osc_running;
   logic [BANK_W-1:0] ref_bank;
   logic [ROW_W-1:0]  ref_row;
   int miscompares = 0;
   int n_compared  = 0;

   rmocr_regs u_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .CE(ce), .MRW_VALID(mrw_valid),
      .MRW_CH(mrw_ch), .MRW_MA(mrw_ma), .MRW_OP(mrw_op), .MRR_VALID(mrr_valid),
      .MRR_CH(mrr_ch), .MRR_MA(mrr_ma), .RD_VALID(rd_valid), .RD_DATA(rd_data),
      .OSC_START(osc_start), .OSC_STOP(osc_stop), .OSC_TICK(osc_tick),
      .OSC_RUNNING(osc_running), .REF_VALID(ref_valid), .REF_CH(ref_ch),
      .REF_BANK(ref_bank), .REF_ROW(ref_row), .DENSITY_4G(density_4g),
      .REF_DONE(ref_done), .REF_SKIPPED(ref_skipped), .CAL_ACTIVE(cal_active),
      .CAL_CH(cal_ch), .CAL_BIT(cal_bit), .DBI_EN(dbi_en), .RD_STROBE(rd_strobe),
      .RD_UPPER_IN(rd_upper_in), .DQ_UPPER_OUT(dq_upper_out),
      .DMI_UPPER_OUT(dmi_upper_out));

   rmocr_ctrl_model u_ctrl (.clk(sys_clk), .rd_valid(rd_valid), .rd_data(rd_data),
      .mrw_valid(mrw_valid), .mrw_ch(mrw_ch), .mrw_ma(mrw_ma), .mrw_op(mrw_op),
      .mrr_valid(mrr_valid), .mrr_ch(mrr_ch), .mrr_ma(mrr_ma));

   // ************************************************************
   // checking helpers
   // ************************************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // a read that never answers ends the run
   task automatic rd_chk(input logic [CH_W-1:0] ch, input logic [MA_W-1:0] ma,
                         input logic [OP_W-1:0] exp);
      logic [OP_W-1:0] d;
      logic            ok;
      u_ctrl.mode_register_read_cmd(ch, ma, d, ok);
      if (!ok)
      begin
         miscompares++;
         test_done();
      end
      chk({8'h00, d}, {8'h00, exp});
   endtask

   task automatic cnt_chk(input logic [CH_W-1:0] ch, input logic [CNT_W-1:0] exp);
      logic [CNT_W-1:0] c;
      logic             ok;
      u_ctrl.read_count(ch, c, ok);
      if (!ok)
      begin
         miscompares++;
         test_done();
      end
      chk(c, exp);
   endtask

   // ************************************************************
   // stimulus helpers
   // ************************************************************
   task automatic refr(input logic [CH_W-1:0] ch, input int bank,
                       input logic [ROW_W-1:0] row, input logic skip);
      @(negedge sys_clk);
      ref_valid = 1'b1;
      ref_ch    = ch;
      ref_bank  = BANK_W'(bank);
      ref_row   = row;
      @(negedge sys_clk);
      ref_valid = 1'b0;
      ref_row   = ~row;
      chk({14'h0000, ref_done, ref_skipped}, {14'h0000, !skip, skip});
   endtask

   task automatic osc(input logic [1:0] st, input logic [1:0] sp);
      @(negedge sys_clk);
      osc_start = st;
      osc_stop  = sp;
      @(negedge sys_clk);
      osc_start = 2'b00;
      osc_stop  = 2'b00;
   endtask

   task automatic tick(input logic [1:0] m, input int n);
      repeat (n)
      begin
         @(negedge sys_clk);
         osc_tick = m;
         @(negedge sys_clk);
         osc_tick = 2'b00;
      end
   endtask

   task automatic beat(input logic c, input logic [CH_W-1:0] ch, input logic b,
                       input logic e, input logic [7:0] d, input logic [7:0] q,
                       input logic m);
      @(negedge sys_clk);
      {cal_active, cal_ch, cal_bit, dbi_en, rd_upper_in} = {c, ch, b, e, d};
      rd_strobe = 1'b1;
      @(negedge sys_clk);
      rd_strobe   = 1'b0;
      rd_upper_in = ~d;
      chk({7'h00, dmi_upper_out, dq_upper_out}, {7'h00, m, q});
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   // different bank masks per channel, bank 0 and 7 as edges
   task automatic t_bank;
      u_ctrl.mrw(1'b0, MA_BANK_MASK, 8'h04);
      u_ctrl.mrw(1'b1, MA_BANK_MASK, 8'h81);
      for (int b = 0; b < 8; b++)
      begin
         refr(1'b0, b, 15'h0000, b == 2);
         refr(1'b1, b, 15'h0000, b == 0 || b == 7);
      end
      // a write offered while the enable is low must not land, so bank 0 stays refreshed
      ce = 1'b0;
      u_ctrl.mrw(1'b0, MA_BANK_MASK, 8'hFF);
      ce = 1'b1;
      refr(1'b0, 0, 15'h0000, 1'b0);
   endtask

   // the row bits below the segment field are set to ones to mislead the wrong density's decode
   task automatic t_seg;
      logic [7:0] m0;
      logic [7:0] m1;
      m0 = 8'h15;
      m1 = 8'hA2;
      u_ctrl.mrw(1'b0, MA_SEG_MASK, m0);
      u_ctrl.mrw(1'b1, MA_SEG_MASK, m1);
      for (int s = 0; s < 8; s++)
      begin
         density_4g = 1'b0;
         refr(1'b0, 3, {1'b0, SEG_W'(s), 11'h7FF}, m0[s]);
         refr(1'b1, 3, {1'b0, SEG_W'(s), 11'h7FF}, m1[s]);
         density_4g = 1'b1;
         refr(1'b0, 3, {SEG_W'(s), 12'hFFF}, m0[s]);
         refr(1'b1, 3, {SEG_W'(s), 12'hFFF}, m1[s]);
      end
   endtask

   // a count above one byte, idle ticks, start winning over stop
   task automatic t_osc;
      tick(2'b11, 3);
      osc(2'b11, 2'b00);
      chk({14'h0000, osc_running}, 16'h0003);
      tick(2'b01, 295);
      tick(2'b11, 5);
      osc(2'b00, 2'b11);
      chk({14'h0000, osc_running}, 16'h0000);
      tick(2'b11, 2);
      u_ctrl.mrw(1'b0, MA_OSC_LOW, 8'h00);
      cnt_chk(1'b0, 16'h012C);
      cnt_chk(1'b1, 16'h0005);
      osc(2'b01, 2'b01);
      chk({14'h0000, osc_running}, 16'h0001);
      cnt_chk(1'b0, 16'h0000);
      cnt_chk(1'b1, 16'h0005);
      osc(2'b00, 2'b01);
   endtask

   // calibration ignores bus inversion although all ones are sent
   task automatic t_cal;
      u_ctrl.mrw(1'b0, MA_UPPER_INV, 8'h15);
      u_ctrl.mrw(1'b1, MA_UPPER_INV, 8'h3C);
      beat(1'b1, 1'b0, 1'b1, 1'b1, 8'h00, 8'hEA, 1'b1);
      beat(1'b1, 1'b0, 1'b0, 1'b1, 8'hFF, 8'h15, 1'b0);
      beat(1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 8'hC3, 1'b1);
      // plain pattern with all ones on the normal path: any inversion would show
      u_ctrl.mrw(1'b1, MA_UPPER_INV, 8'h00);
      beat(1'b1, 1'b1, 1'b0, 1'b1, 8'hFF, 8'h00, 1'b0);
      beat(1'b0, 1'b0, 1'b0, 1'b1, 8'hF8, 8'h07, 1'b1);
      beat(1'b0, 1'b0, 1'b0, 1'b1, 8'hF0, 8'hF0, 1'b0);
      beat(1'b0, 1'b0, 1'b0, 1'b0, 8'hF8, 8'hF8, 1'b0);
      rd_chk(1'b0, MA_UPPER_INV, 8'h00);
      rd_chk(1'b0, MA_SEG_MASK, 8'h00);
      rd_chk(1'b1, MA_BANK_MASK, 8'h00);
      rd_chk(1'b0, 6'h00, 8'h00);
   endtask

   // clock source
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // main sequence; the first request waits out the reset synchroniser
   initial
   begin
      {rst_n, ref_valid, density_4g, cal_active, cal_bit, dbi_en, rd_strobe} = '0;
      {ref_ch, cal_ch, ref_bank, ref_row, rd_upper_in} = '0;
      {osc_start, osc_stop, osc_tick} = '0;
      ce = 1'b1;
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk({7'h00, rd_valid, dq_upper_out}, 16'h0000);
      cnt_chk(1'b0, CNT_RST);
      t_bank();
      t_seg();
      t_osc();
      t_cal();
      test_done();
   end
endmodule // refresh_mask_osc_count_regs_tb
